/* core/sfps_defines.svh */
// constants of the serial flash protection and status block
// Functional notes
// - keep 136 permanent lock bits, one per protectable block.
// - writing one to a permanent lock bit forces its block write-lock one forever.
// - a zero written to a permanent lock bit changes nothing.
// - while lock-down is active, permanent lock writes are ignored.
// - guard pin acts only with io config bit zero; at one pin and enable are void.
// - with guard pin enable zero the guard pin level is ignored.
// - guard pin enable is non-volatile with factory value zero.
// - guard pin affects only guard and config writes, never program or erase.
// - pin low, io config zero, enable one: refuse guard and config writes.
// - lock-down active refuses block guard writes whatever pin and config say.
// - identifier space 2 KByte; first 64 bits fixed; no erase of it at all.
// - after identifier lockout every identifier program is rejected.
// - pause pin works only in single and dual SPI, never in quad mode.
// - pause enters or leaves when clock low at the pin edge, else at next low.
// - while paused, serial output floats and serial input and clock are ignored.
// - chip select high during pause resets interface; resume needs pause high, select low.
// - status byte: busy, wel, erase susp, program susp, lockdown, id locked, zero, busy.
// - identifier locked bit powers up one only after a completed lockout; the core resets it to zero on i_resetn, soft reset keeps it.
// - with write-enable latch zero, refuse program, erase, guard writes and lock-down.
// - clear write-enable latch on reset, disable, suspend, status write, completions, guard cmds.
// - status reads are allowed while an internal program or erase runs.
// - lock-down persists until power cycle; nothing else clears it.
// - with io config bit one, guard and pause pins are quad data lines.
`ifndef SFPS_DEFINES_SVH
`define SFPS_DEFINES_SVH
`define SFPS_OFS_STATUS       8'h00
`define SFPS_OFS_CONFIG       8'h04
`define SFPS_OFS_CMD          8'h08
`define SFPS_OFS_RESULT       8'h0c
`define SFPS_WIN_STAGE        3'h1
`define SFPS_WIN_GUARD        3'h2
`define SFPS_WIN_PERM         3'h3
`define SFPS_WIN_WORDS        3'h5
`define SFPS_CFG_IOC_BIT      1
`define SFPS_CFG_BPNV_BIT     3
`define SFPS_CFG_PIN_EN_BIT   7
`define SFPS_PIN_EN_RESET     1'b0
`define SFPS_ID_BYTES         12'h800
`define SFPS_ID_FIXED_BYTES   12'h008
`define SFPS_NUM_BLOCKS       8'h88
`define SFPS_OP_TIME_NS       2000
`define SFPS_CLK_PERIOD_NS    50
`define SFPS_OP_CYCLES ((`SFPS_OP_TIME_NS + `SFPS_CLK_PERIOD_NS - 1) / `SFPS_CLK_PERIOD_NS)
`endif

/* core/sfps_pkg.sv */
// types of the serial flash protection and status block
package sfps_pkg;
	typedef enum logic [4:0] {
		CMD_NOP, CMD_WRITE_ENABLE, CMD_WRITE_DISABLE, CMD_WRITE_BLOCK_GUARD,
		CMD_LOCKDOWN_GUARD, CMD_WRITE_PERM_LOCK, CMD_PROGRAM_IDENTIFIER,
		CMD_LOCKOUT_IDENTIFIER, CMD_WRITE_STATUS, CMD_WRITE_SUSPEND, CMD_WRITE_RESUME,
		CMD_PAGE_PROGRAM, CMD_QUAD_PAGE_PROGRAM, CMD_SECTOR_ERASE, CMD_BLOCK_ERASE,
		CMD_CHIP_ERASE, CMD_SOFT_RESET, CMD_QUAD_ENTER, CMD_QUAD_EXIT
	} sfps_cmd_t;

	typedef struct packed {
		logic [1:0]   sck_s;
		logic [1:0]   ce_s;
		logic [1:0]   wp_s;
		logic [1:0]   pause_s;
		logic [1:0]   si_s;
		logic         sck_prev;
		logic         hold;
		logic         write_enable_latch;
		logic         busy;
		logic         erase_susp;
		logic         prog_susp;
		logic         lockdown;
		logic         id_locked;
		logic         io_config;
		logic         pin_en;
		logic         quad_mode;
		logic         refused;
		logic         op_erase;
		logic         op_id_lock;
		logic [15:0]  busy_cnt;
		logic [135:0] write_lock;
		logic [7:0]   read_lock;
		logic [135:0] perm_lock;
		logic [143:0] stage;
		logic         acc;
		logic [31:0]  rdata;
		logic         so;
		logic         so_oe;
		logic         dq2;
		logic         dq2_oe;
		logic         dq3;
		logic         dq3_oe;
		logic         sck_rise;
		logic         si;
		logic         iface_rst;
	} sfps_state_t;
endpackage : sfps_pkg

/* core/sfps_core.sv */
// protection, lock-down, identifier lock, pause and status logic of a serial flash
`timescale 1ns/1ps
`include "sfps_defines.svh"
module sfps_core import sfps_pkg::*; #(
	parameter int         OP_CYCLES         = `SFPS_OP_CYCLES,
	parameter logic       IO_CONFIG_DEFAULT = 1'b0
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_sck,
	input  wire logic        i_ce_n,
	input  wire logic        i_si,
	input  wire logic        i_so_data,
	input  wire logic        i_so_en,
	output logic             o_so,
	output logic             o_so_oe,
	input  wire logic        i_dq2,
	output logic             o_dq2,
	output logic             o_dq2_oe,
	input  wire logic        i_dq3,
	output logic             o_dq3,
	output logic             o_dq3_oe,
	input  wire logic [1:0]  i_quad_dq_out,
	input  wire logic [1:0]  i_quad_dq_oe,
	output logic             o_sck_rise,
	output logic             o_si,
	output logic             o_paused,
	output logic             o_iface_reset
);

	////////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	if (OP_CYCLES < 1 || OP_CYCLES > 65535) begin : g_bad_op_cycles
		$error("OP_CYCLES must lie in 1..65535");
	end

	////////////////////////////////////////////////////////////////////////////////
	// functions

	// selects one 32-bit word of a 144-bit window
	function automatic logic [31:0] word_of(input logic [143:0] v, input logic [2:0] k);
		logic [159:0] w;
		w = {16'h0, v} >> {k, 5'h0};
		return w[31:0];
	endfunction : word_of

	// true when a block index names an existing block
	function automatic logic blk_ok(input logic [7:0] b);
		return b < `SFPS_NUM_BLOCKS;
	endfunction : blk_ok

	////////////////////////////////////////////////////////////////////////////////
	// state

	sfps_state_t r_reg;
	sfps_state_t r_next;

	localparam logic [15:0] OP_CNT = OP_CYCLES[15:0];

	logic       access;
	logic       wr_go;
	logic [7:0] status_byte;
	logic [7:0] config_byte;

	assign access  = (i_avs_read | i_avs_write) & ~r_reg.acc;
	assign wr_go   = i_avs_write & r_reg.acc;

	assign status_byte = {r_reg.busy, 1'b0, r_reg.id_locked, r_reg.lockdown,
		r_reg.prog_susp, r_reg.erase_susp, r_reg.write_enable_latch, r_reg.busy};
	assign config_byte = {r_reg.pin_en, 3'h0, ~|r_reg.perm_lock, 1'b0, r_reg.io_config, 1'b0};

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		sfps_cmd_t   cmd;
		logic [7:0]  blk;
		logic [11:0] id_addr;
		logic [7:0]  cfg_val;
		logic        pin_guard;
		logic        pause_en;
		logic        quad_lines;
		logic        ce_act;
		logic [2:0]  k;
		logic        ok;
		cmd        = sfps_cmd_t'(i_avs_writedata[4:0]);
		blk        = i_avs_writedata[15:8];
		id_addr    = i_avs_writedata[27:16];
		cfg_val    = i_avs_writedata[23:16];
		k          = i_avs_address[4:2];
		ok         = 1'b0;
		quad_lines = r_reg.io_config | r_reg.quad_mode;
		pause_en   = ~r_reg.io_config & ~r_reg.quad_mode;
		pin_guard  = ~r_reg.io_config & ~r_reg.quad_mode & r_reg.pin_en & ~r_reg.wp_s[1];
		ce_act     = ~r_reg.ce_s[1];
		r_next     = r_reg;

		// pin synchronisers
		r_next.sck_s    = {r_reg.sck_s[0], i_sck};
		r_next.ce_s     = {r_reg.ce_s[0], i_ce_n};
		r_next.wp_s     = {r_reg.wp_s[0], i_dq2};
		r_next.pause_s  = {r_reg.pause_s[0], i_dq3};
		r_next.si_s     = {r_reg.si_s[0], i_si};
		r_next.sck_prev = r_reg.sck_s[1];

		// pause control
		if (!ce_act) begin
			r_next.hold = 1'b0;
		end else if (!pause_en) begin
			r_next.hold = 1'b0;
		end else if (!r_reg.sck_s[1]) begin
			r_next.hold = ~r_reg.pause_s[1];
		end
		r_next.iface_rst = ~ce_act;
		r_next.sck_rise  = r_reg.sck_s[1] & ~r_reg.sck_prev & ~r_reg.hold & ce_act;
		r_next.si        = r_reg.hold ? r_reg.si : r_reg.si_s[1];
		r_next.so        = i_so_data;
		r_next.so_oe     = i_so_en & ce_act & ~r_reg.hold;

		// quad data lines
		r_next.dq2    = i_quad_dq_out[0];
		r_next.dq3    = i_quad_dq_out[1];
		r_next.dq2_oe = quad_lines & i_quad_dq_oe[0];
		r_next.dq3_oe = quad_lines & i_quad_dq_oe[1];

		// internal write timer
		if (r_reg.busy) begin
			if (r_reg.busy_cnt <= 16'h1) begin
				r_next.busy       = 1'b0;
				r_next.write_enable_latch        = 1'b0;
				r_next.busy_cnt   = 16'h0;
				r_next.id_locked  = r_reg.id_locked | r_reg.op_id_lock;
				r_next.op_id_lock = 1'b0;
			end else begin
				r_next.busy_cnt = r_reg.busy_cnt - 16'h1;
			end
		end

		// bus handshake and read data
		r_next.acc = access;
		if (access && i_avs_read) begin
			case (i_avs_address[7:5])
				3'h0: begin
					case (i_avs_address)
						`SFPS_OFS_STATUS: r_next.rdata = {24'h0, status_byte};
						`SFPS_OFS_CONFIG: r_next.rdata = {24'h0, config_byte};
						`SFPS_OFS_RESULT: r_next.rdata = {28'h0, r_reg.quad_mode, r_reg.hold,
							r_reg.busy, r_reg.refused};
						default:          r_next.rdata = 32'h0;
					endcase
				end
				`SFPS_WIN_STAGE: r_next.rdata = (k < `SFPS_WIN_WORDS) ?
					word_of(r_reg.stage, k) : 32'h0;
				`SFPS_WIN_GUARD: r_next.rdata = (k < `SFPS_WIN_WORDS) ?
					word_of({r_reg.read_lock, r_reg.write_lock}, k) : 32'h0;
				`SFPS_WIN_PERM:  r_next.rdata = (k < `SFPS_WIN_WORDS) ?
					word_of({8'h0, r_reg.perm_lock}, k) : 32'h0;
				default:         r_next.rdata = 32'h0;
			endcase
		end

		// staging window writes
		if (wr_go && i_avs_address[7:5] == `SFPS_WIN_STAGE && k < `SFPS_WIN_WORDS) begin
			for (int b = 0; b < 4; b++) begin
				if (i_avs_byteenable[b] && (32'(k) * 4 + b) < 18) begin
					r_next.stage[(32'(k) * 32 + b * 8) +: 8] = i_avs_writedata[b * 8 +: 8];
				end
			end
		end

		// command execution
		if (wr_go && i_avs_address == `SFPS_OFS_CMD && i_avs_byteenable[0]) begin
			case (cmd)
				CMD_NOP: begin
					ok = 1'b1;
				end
				CMD_WRITE_ENABLE: begin
					ok = ~r_reg.busy;
					if (ok) begin
						r_next.write_enable_latch = 1'b1;
					end
				end
				CMD_WRITE_DISABLE: begin
					ok         = 1'b1;
					r_next.write_enable_latch = 1'b0;
				end
				CMD_WRITE_BLOCK_GUARD: begin
					ok = r_reg.write_enable_latch & ~r_reg.busy & ~r_reg.lockdown & ~pin_guard;
					if (ok) begin
						r_next.write_lock = r_reg.stage[135:0] | r_reg.perm_lock;
						r_next.read_lock  = r_reg.stage[143:136];
					end
					r_next.write_enable_latch = 1'b0;
				end
				CMD_LOCKDOWN_GUARD: begin
					ok = r_reg.write_enable_latch & ~r_reg.busy;
					if (ok) begin
						r_next.lockdown = 1'b1;
					end
					r_next.write_enable_latch = 1'b0;
				end
				CMD_WRITE_PERM_LOCK: begin
					ok = r_reg.write_enable_latch & ~r_reg.busy & ~r_reg.lockdown;
					if (ok) begin
						r_next.perm_lock  = r_reg.perm_lock | r_reg.stage[135:0];
						r_next.write_lock = r_reg.write_lock | r_reg.stage[135:0];
					end
					r_next.write_enable_latch = 1'b0;
				end
				CMD_WRITE_STATUS: begin
					ok = r_reg.write_enable_latch & ~r_reg.busy & ~pin_guard;
					if (ok) begin
						r_next.io_config = cfg_val[`SFPS_CFG_IOC_BIT];
						r_next.pin_en    = cfg_val[`SFPS_CFG_PIN_EN_BIT];
					end
					r_next.write_enable_latch = 1'b0;
				end
				CMD_PROGRAM_IDENTIFIER: begin
					ok = r_reg.write_enable_latch & ~r_reg.busy & ~r_reg.id_locked
						& (id_addr >= `SFPS_ID_FIXED_BYTES) & (id_addr < `SFPS_ID_BYTES);
					if (ok) begin
						r_next.busy     = 1'b1;
						r_next.busy_cnt = OP_CNT;
						r_next.op_erase = 1'b0;
					end
				end
				CMD_LOCKOUT_IDENTIFIER: begin
					ok = r_reg.write_enable_latch & ~r_reg.busy & ~r_reg.id_locked;
					if (ok) begin
						r_next.busy       = 1'b1;
						r_next.busy_cnt   = OP_CNT;
						r_next.op_erase   = 1'b0;
						r_next.op_id_lock = 1'b1;
					end
				end
				CMD_WRITE_SUSPEND: begin
					ok = r_reg.busy & ~r_reg.op_id_lock;
					if (ok) begin
						r_next.busy       = 1'b0;
						r_next.erase_susp = r_reg.op_erase;
						r_next.prog_susp  = ~r_reg.op_erase;
					end
					r_next.write_enable_latch = 1'b0;
				end
				CMD_WRITE_RESUME: begin
					ok = ~r_reg.busy & (r_reg.erase_susp | r_reg.prog_susp);
					if (ok) begin
						r_next.busy       = 1'b1;
						r_next.erase_susp = 1'b0;
						r_next.prog_susp  = 1'b0;
					end
				end
				CMD_PAGE_PROGRAM, CMD_QUAD_PAGE_PROGRAM, CMD_SECTOR_ERASE, CMD_BLOCK_ERASE: begin
					// the guard pin plays no part here
					ok = r_reg.write_enable_latch & ~r_reg.busy & ~r_reg.erase_susp & ~r_reg.prog_susp
						& blk_ok(blk) & ~r_reg.write_lock[blk];
					if (cmd == CMD_QUAD_PAGE_PROGRAM && !quad_lines) begin
						ok = 1'b0;
					end
					if (ok) begin
						r_next.busy     = 1'b1;
						r_next.busy_cnt = OP_CNT;
						r_next.op_erase = (cmd == CMD_SECTOR_ERASE) || (cmd == CMD_BLOCK_ERASE);
					end
				end
				CMD_CHIP_ERASE: begin
					ok = r_reg.write_enable_latch & ~r_reg.busy & ~r_reg.erase_susp & ~r_reg.prog_susp
						& ~|r_reg.write_lock;
					if (ok) begin
						r_next.busy     = 1'b1;
						r_next.busy_cnt = OP_CNT;
						r_next.op_erase = 1'b1;
					end
				end
				CMD_SOFT_RESET: begin
					// lock-down and non-volatile bits survive
					ok                = 1'b1;
					r_next.write_enable_latch        = 1'b0;
					r_next.busy       = 1'b0;
					r_next.busy_cnt   = 16'h0;
					r_next.op_id_lock = 1'b0;
					r_next.erase_susp = 1'b0;
					r_next.prog_susp  = 1'b0;
					r_next.quad_mode  = 1'b0;
				end
				CMD_QUAD_ENTER: begin
					ok               = ~r_reg.busy;
					r_next.quad_mode = ok | r_reg.quad_mode;
				end
				CMD_QUAD_EXIT: begin
					ok               = ~r_reg.busy;
					r_next.quad_mode = ~ok & r_reg.quad_mode;
				end
				default: begin
					ok = 1'b0;
				end
			endcase
			r_next.refused = ~ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r_reg           <= '0;
			r_reg.sck_s     <= 2'h0;
			r_reg.ce_s      <= 2'h3;
			r_reg.wp_s      <= 2'h3;
			r_reg.pause_s   <= 2'h3;
			r_reg.iface_rst <= 1'b1;
			r_reg.io_config <= IO_CONFIG_DEFAULT;
			r_reg.pin_en    <= `SFPS_PIN_EN_RESET;
			r_reg.write_enable_latch       <= 1'b0;
			r_reg.lockdown  <= 1'b0;
			r_reg.id_locked <= 1'b0;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_avs_waitrequest = access;
	assign o_avs_readdata    = r_reg.rdata;
	assign o_so              = r_reg.so;
	assign o_so_oe           = r_reg.so_oe;
	assign o_dq2             = r_reg.dq2;
	assign o_dq2_oe          = r_reg.dq2_oe;
	assign o_dq3             = r_reg.dq3;
	assign o_dq3_oe          = r_reg.dq3_oe;
	assign o_sck_rise        = r_reg.sck_rise;
	assign o_si              = r_reg.si;
	assign o_paused          = r_reg.hold;
	assign o_iface_reset     = r_reg.iface_rst;

endmodule : sfps_core

/* sim/sfps_core_sva.sv */
// port assertions of the serial flash protection block
`timescale 1ns/1ps
module sfps_core_sva (
	input wire logic        i_ref_clk,
	input wire logic        i_resetn,
	input wire logic [7:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic        i_sck,
	input wire logic        i_ce_n,
	input wire logic        i_dq3,
	input wire logic        o_so_oe,
	input wire logic        o_sck_rise,
	input wire logic        o_si,
	input wire logic        o_paused,
	input wire logic        o_iface_reset
);
	default clocking dc @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	////////////////////////////////////////////////////////////////////////////////
	property p_one_wait;
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("request not answered");
	property p_status_fmt;
		i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h00 |->
			o_avs_readdata[31:6] == {24'h000000, o_avs_readdata[0], 1'b0};
	endproperty
	a_status_fmt: assert property (p_status_fmt) else $error("status layout wrong");
	property p_so_float;
		o_paused && $past(o_paused) |-> !o_so_oe;
	endproperty
	a_so_float: assert property (p_so_float) else $error("output driven in pause");
	property p_no_rise;
		o_paused && $past(o_paused) |-> !o_sck_rise;
	endproperty
	a_no_rise: assert property (p_no_rise) else $error("clock edge seen in pause");
	property p_si_frozen;
		o_paused && $past(o_paused) |-> $stable(o_si);
	endproperty
	a_si_frozen: assert property (p_si_frozen) else $error("input moved in pause");
	property p_pause_entry;
		$rose(o_paused) |-> !$past(i_dq3, 2) && !$past(i_ce_n, 2) && !$past(i_sck, 2);
	endproperty
	a_pause_entry: assert property (p_pause_entry) else $error("bad pause entry");
	property p_ce_pause;
		i_ce_n [*5] |-> !o_paused;
	endproperty
	a_ce_pause: assert property (p_ce_pause) else $error("pause kept when deselected");
	property p_ce_iface;
		i_ce_n [*5] |-> o_iface_reset;
	endproperty
	a_ce_iface: assert property (p_ce_iface) else $error("interface not reset");
endmodule : sfps_core_sva
bind sfps_core sfps_core_sva sfps_core_sva_i (
	.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_sck(i_sck), .i_ce_n(i_ce_n), .i_dq3(i_dq3),
	.o_so_oe(o_so_oe), .o_sck_rise(o_sck_rise), .o_si(o_si), .o_paused(o_paused),
	.o_iface_reset(o_iface_reset));

/* sim/sfps_host_model.sv */
// host controller model driving the serial flash link pins
`timescale 1ns/1ps
module sfps_host_model (
	input  wire logic i_ref_clk,
	output logic      o_sck,
	output logic      o_ce_n,
	output logic      o_si,
	output logic      o_wp_n,
	output logic      o_hold_n
);
	initial begin
		o_sck = 1'b0;
		o_ce_n = 1'b1;
		o_si = 1'b0;
		o_wp_n = 1'b1;
		o_hold_n = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one half period of the 400 ns serial clock, data moves while low
	task automatic half(input logic lvl);
		@(posedge i_ref_clk);
		o_sck <= lvl;
		if (!lvl) o_si <= ~o_si;
		repeat (3) @(posedge i_ref_clk);
	endtask : half
	// select or release; clock stands low and serial input flips
	task automatic frame(input logic sel);
		@(posedge i_ref_clk);
		o_ce_n <= !sel;
		o_sck <= 1'b0;
		o_si <= ~o_si;
	endtask : frame
	// guard and pause pin levels, both driven whether selected or not
	task automatic pins(input logic wp_n, input logic hold_n);
		@(posedge i_ref_clk);
		o_wp_n <= wp_n;
		o_hold_n <= hold_n;
	endtask : pins
endmodule : sfps_host_model

/* sim/test_serial_flash_protection_status.sv */
// self-checking bench of the serial flash protection block
`timescale 1ns/1ps
`include "sfps_defines.svh"
module test_serial_flash_protection_status import sfps_pkg::*;;
	logic        ref_clk, resetn, rd, wr, sck, ce_n, si, wp_n, hold_n;
	logic [3:0]  be;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, q;
	logic        waitreq, so, so_oe, dq2_o, dq2_oe, dq3_o, dq3_oe, rise, si_o, paused, ifrst;
	wire logic   dq2, dq3;
	logic [39:0] rows [$];
	logic [39:0] r;
	int          fail_count, checked, cycles, rises;
	assign dq2 = dq2_oe ? dq2_o : wp_n;
	assign dq3 = dq3_oe ? dq3_o : hold_n;
	sfps_core #(.OP_CYCLES(40)) sfps_core_i (
		.i_ref_clk(ref_clk), .i_resetn(resetn), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_sck(sck), .i_ce_n(ce_n),
		.i_si(si), .i_so_data(1'b0), .i_so_en(1'b1), .o_so(so), .o_so_oe(so_oe), .i_dq2(dq2),
		.o_dq2(dq2_o), .o_dq2_oe(dq2_oe), .i_dq3(dq3), .o_dq3(dq3_o), .o_dq3_oe(dq3_oe),
		.i_quad_dq_out(2'h0), .i_quad_dq_oe(2'h0), .o_sck_rise(rise), .o_si(si_o),
		.o_paused(paused), .o_iface_reset(ifrst));
	sfps_host_model sfps_host_model_i (.i_ref_clk(ref_clk), .o_sck(sck), .o_ce_n(ce_n),
		.o_si(si), .o_wp_n(wp_n), .o_hold_n(hold_n));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (rise === 1'b1) rises <= rises + 1;
		if (cycles == 30000) begin
			fail_count++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : check
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		be <= 4'hf;
		do begin
			@(negedge ref_clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		q = rdata;
		@(posedge ref_clk);
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50) fail_count++;
	endtask : bus
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check($sformatf("register %h", a), e, q);
	endtask : rdc
	task automatic we;
		bus(1'b1, `SFPS_OFS_CMD, 32'h1);
	endtask : we
	task automatic cmd(input logic [4:0] op, input logic [23:0] arg, input logic refd,
		input logic [7:0] st, input logic idle);
		bus(1'b1, `SFPS_OFS_CMD, {arg, 3'h0, op});
		bus(1'b0, `SFPS_OFS_RESULT, 32'h0);
		check("refused", {31'h0, refd}, {31'h0, q[0]});
		rdc(`SFPS_OFS_STATUS, {24'h0, st});
		repeat (60) if (idle && q[0] !== 1'b0) bus(1'b0, `SFPS_OFS_STATUS, 32'h0);
		if (idle) check("busy", 32'h0, {31'h0, q[0]});
	endtask : cmd
	// pause pin pulled low with clock low must be ignored here
	task automatic no_pause(input logic wp);
		sfps_host_model_i.frame(1'b1);
		sfps_host_model_i.pins(wp, 1'b0);
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		check("paused", 32'h0, {31'h0, paused});
		sfps_host_model_i.pins(wp, 1'b1);
		sfps_host_model_i.frame(1'b0);
	endtask : no_pause
	////////////////////////////////////////////////////////////////////////////////
	// rows: opcode, flags {refused, wait idle}, status, identifier address
	initial begin
		{resetn, rd, wr, addr, wdata, be, fail_count, checked, cycles, rises} = '0;
		rows = '{40'h01_01_02_0000, 40'h02_01_00_0000, 40'h04_11_00_0000, 40'h13_11_00_0000,
			40'h01_01_02_0000, 40'h0d_01_83_0000, 40'h00_01_00_0000, 40'h01_01_02_0000,
			40'h0b_00_83_0000, 40'h09_01_08_0000, 40'h0a_01_81_0000, 40'h01_01_02_0000,
			40'h0d_00_83_0000, 40'h09_01_04_0000, 40'h0a_01_81_0000, 40'h00_01_00_0000,
			40'h01_01_02_0000, 40'h06_11_02_0004, 40'h06_01_83_0100, 40'h00_01_00_0000,
			40'h01_01_02_0000, 40'h06_11_02_0800, 40'h07_01_83_0000, 40'h00_01_20_0000,
			40'h01_01_22_0000, 40'h06_11_22_0100, 40'h02_01_20_0000, 40'h01_01_22_0000,
			40'h04_01_30_0000, 40'h01_01_32_0000, 40'h03_11_30_0000, 40'h01_01_32_0000,
			40'h05_11_30_0000, 40'h10_01_30_0000};
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		foreach (rows[i]) begin
			r = rows[i];
			cmd(r[36:32], {4'h0, r[11:0], 8'h00}, r[28], r[23:16], r[24]);
		end
		sfps_host_model_i.frame(1'b1);
		sfps_host_model_i.half(1'b1);
		sfps_host_model_i.half(1'b0);
		sfps_host_model_i.half(1'b1);
		sfps_host_model_i.pins(1'b1, 1'b0);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		check("paused", 32'h0, {31'h0, paused});
		sfps_host_model_i.half(1'b0);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		check("paused", 32'h1, {31'h0, paused});
		check("so_oe", 32'h0, {31'h0, so_oe});
		sfps_host_model_i.half(1'b1);
		sfps_host_model_i.half(1'b0);
		sfps_host_model_i.frame(1'b0);
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		check("paused", 32'h0, {31'h0, paused});
		check("iface", 32'h1, {31'h0, ifrst});
		check("rises", 32'h2, rises);
		sfps_host_model_i.pins(1'b1, 1'b1);
		cmd(5'h11, 24'h0, 1'b0, 8'h30, 1'b1);
		no_pause(1'b1);
		cmd(5'h12, 24'h0, 1'b0, 8'h30, 1'b1);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		rdc(`SFPS_OFS_STATUS, 32'h0);
		rdc(`SFPS_OFS_CONFIG, 32'h08);
		rdc(8'hfc, 32'h0);
		bus(1'b1, 8'h20, 32'h5);
		we();
		cmd(5'h05, 24'h0, 1'b0, 8'h00, 1'b1);
		rdc(8'h60, 32'h5);
		rdc(8'h40, 32'h5);
		rdc(`SFPS_OFS_CONFIG, 32'h0);
		bus(1'b1, 8'h20, 32'h0);
		we();
		cmd(5'h03, 24'h0, 1'b0, 8'h00, 1'b1);
		rdc(8'h40, 32'h5);
		we();
		cmd(5'h05, 24'h0, 1'b0, 8'h00, 1'b1);
		rdc(8'h60, 32'h5);
		bus(1'b1, 8'h30, 32'h180);
		we();
		cmd(5'h05, 24'h0, 1'b0, 8'h00, 1'b1);
		rdc(8'h70, 32'h80);
		we();
		cmd(5'h0d, 24'h0, 1'b1, 8'h02, 1'b1);
		cmd(5'h02, 24'h0, 1'b0, 8'h00, 1'b1);
		we();
		cmd(5'h08, 24'h008000, 1'b0, 8'h00, 1'b1);
		rdc(`SFPS_OFS_CONFIG, 32'h80);
		sfps_host_model_i.pins(1'b0, 1'b1);
		we();
		cmd(5'h03, 24'h0, 1'b1, 8'h00, 1'b1);
		we();
		cmd(5'h08, 24'h0, 1'b1, 8'h00, 1'b1);
		rdc(`SFPS_OFS_CONFIG, 32'h80);
		we();
		cmd(5'h0d, 24'h000001, 1'b0, 8'h83, 1'b1);
		sfps_host_model_i.pins(1'b1, 1'b1);
		we();
		cmd(5'h08, 24'h008200, 1'b0, 8'h00, 1'b1);
		rdc(`SFPS_OFS_CONFIG, 32'h82);
		sfps_host_model_i.pins(1'b0, 1'b1);
		we();
		cmd(5'h03, 24'h0, 1'b0, 8'h00, 1'b1);
		no_pause(1'b0);
		we();
		cmd(5'h08, 24'h0, 1'b0, 8'h00, 1'b1);
		rdc(`SFPS_OFS_CONFIG, 32'h0);
		we();
		cmd(5'h03, 24'h0, 1'b0, 8'h00, 1'b1);
		close_out();
	end
endmodule : test_serial_flash_protection_status
